//--- include/phy_port_pkg.sv
package phy_port_pkg;
   // memory geometry; defaults chosen for a plain x8 device
   localparam int MEMORY_DATA_WIDTH   = 8;
   localparam int RATE_RATIO          = 4;
   localparam int PHASES              = RATE_RATIO / 2;
   localparam int ROW_ADDRESS_WIDTH   = 13;
   localparam int BANK_ADDRESS_WIDTH  = 3;
   localparam int CHIP_SELECT_COUNT   = 1;
   localparam int STROBE_GROUP_COUNT  = 1;
   localparam int CLOCK_PAIR_COUNT    = 1;
   localparam int LATENCY_FIELD_WIDTH = 5;
   localparam int WRITE_LAT_WIDTH     = 5;
   localparam int RDATA_WIDTH   = MEMORY_DATA_WIDTH * RATE_RATIO;
   localparam int PHASE_WIDTH   = MEMORY_DATA_WIDTH * PHASES;
   localparam int CS_PH_WIDTH   = CHIP_SELECT_COUNT * PHASES;
   localparam int DRD_WIDTH     = STROBE_GROUP_COUNT * PHASES;
   localparam int LANE_WIDTH    = STROBE_GROUP_COUNT * CHIP_SELECT_COUNT;

   // timing
   localparam int CLK_PERIOD_NS  = 20;
   localparam int CAL_SETTLE_NS  = 1000;
   localparam int CAL_SETTLE_CYC =
      (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_TIMEOUT_CYC = 31;
   localparam int RD_WINDOW_CYC   = 8;

   // command codes {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_NOP   = 3'h7;
   localparam logic [2:0] CMD_READ  = 3'h5;

   typedef enum logic [1:0] {
      CAL_SETTLE = 2'b00,
      CAL_PROBE  = 2'b01,
      CAL_WAIT   = 2'b10,
      CAL_DONE   = 2'b11
   } cal_state_t;
endpackage

//--- include/phy_port_if.sv
`timescale 1ns/10ps
interface phy_port_if;
   import phy_port_pkg::*;
   logic [RDATA_WIDTH-1:0]         rdata;
   logic [PHASES-1:0]              rdata_valid;
   logic                           rdata_ready;
   logic [LATENCY_FIELD_WIDTH-1:0] rlat;
   logic [WRITE_LAT_WIDTH-1:0]     wlat;
   logic [DRD_WIDTH-1:0]           doing_rd;
   logic [ROW_ADDRESS_WIDTH*PHASES-1:0]  addr;
   logic [BANK_ADDRESS_WIDTH*PHASES-1:0] ba;
   logic [CS_PH_WIDTH-1:0]         cke;
   logic [CS_PH_WIDTH-1:0]         cs_n;
   logic [CS_PH_WIDTH-1:0]         odt;
   logic [PHASES-1:0]              ras_n;
   logic [PHASES-1:0]              cas_n;
   logic [PHASES-1:0]              we_n;
   logic [PHASES-1:0]              rst_n;
   logic [CLOCK_PAIR_COUNT-1:0]    mem_clk_disable;
   logic                           cal_success;
   logic                           cal_fail;
   logic                           cal_req;
   logic [LANE_WIDTH-1:0]          cal_byte_lane_sel_n;

   modport phy (
      output rdata, rdata_valid, rlat, wlat, cal_success, cal_fail,
      input  rdata_ready, doing_rd, addr, ba, cke, cs_n, odt,
      input  ras_n, cas_n, we_n, rst_n, mem_clk_disable,
      input  cal_req, cal_byte_lane_sel_n
   );
   modport ctl (
      input  rdata, rdata_valid, rlat, wlat, cal_success, cal_fail,
      output rdata_ready, doing_rd, addr, ba, cke, cs_n, odt,
      output ras_n, cas_n, we_n, rst_n, mem_clk_disable,
      output cal_req, cal_byte_lane_sel_n
   );
endinterface

//--- hw/phy_cmd_read_cal.sv
`timescale 1ns/10ps
module phy_cmd_read_cal
   import phy_port_pkg::*;
(
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // controller side
   phy_port_if.phy                         ctl,
   // memory pins: command
   output logic [ROW_ADDRESS_WIDTH*PHASES-1:0]  mem_addr_o,
   output logic [BANK_ADDRESS_WIDTH*PHASES-1:0] mem_ba_o,
   output logic [CS_PH_WIDTH-1:0]          mem_cke_o,
   output logic [CS_PH_WIDTH-1:0]          mem_cs_n_o,
   output logic [CS_PH_WIDTH-1:0]          mem_odt_o,
   output logic [PHASES-1:0]               mem_ras_n_o,
   output logic [PHASES-1:0]               mem_cas_n_o,
   output logic [PHASES-1:0]               mem_we_n_o,
   output logic [PHASES-1:0]               mem_rst_n_o,
   output logic [CLOCK_PAIR_COUNT-1:0]     mem_clk_en_o,
   // memory pins: read capture
   input  wire logic [RDATA_WIDTH-1:0]     mem_rdata_i,
   input  wire logic [PHASES-1:0]          mem_dqs_i,
   output logic                            rd_accept_o
);

   cal_state_t                     state_q;
   logic [7:0]                     cnt_q;
   logic [RDATA_WIDTH-1:0]         rdata_s1_q;
   logic [RDATA_WIDTH-1:0]         rdata_s2_q;
   logic [PHASES-1:0]              dqs_s1_q;
   logic [PHASES-1:0]              dqs_s2_q;
   logic [3:0]                     win_q;
   logic [LATENCY_FIELD_WIDTH-1:0] lat_cnt_q;
   logic                           lat_armed_q;
   logic [LATENCY_FIELD_WIDTH-1:0] rlat_q;
   logic [WRITE_LAT_WIDTH-1:0]     wlat_q;
   logic                           success_q;
   logic                           fail_q;
   logic                           probe;
   logic                           read_start;
   logic                           in_valid;
   logic                           push;
   logic                           pop;
   logic [RDATA_WIDTH-1:0]         head_q;
   logic [PHASES-1:0]              head_ph_q;
   logic [RDATA_WIDTH-1:0]         spare_q;
   logic [PHASES-1:0]              spare_ph_q;
   logic                           spare_v_q;

   assign probe      = (state_q == CAL_PROBE);
   assign read_start = probe || (success_q && (|ctl.doing_rd));
   assign in_valid   = (win_q != 4'h0) && (|dqs_s2_q);
   assign push       = in_valid && !spare_v_q;
   assign pop        = (|head_ph_q) && ctl.rdata_ready;

   // capture synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_s1_q <= '0;
         rdata_s2_q <= '0;
         dqs_s1_q   <= '0;
         dqs_s2_q   <= '0;
      end else begin
         rdata_s1_q <= mem_rdata_i;
         rdata_s2_q <= rdata_s1_q;
         dqs_s1_q   <= mem_dqs_i;
         dqs_s2_q   <= dqs_s1_q;
      end
   end

   // calibration sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= CAL_SETTLE;
         cnt_q   <= 8'h00;
      end else begin
         unique case (state_q)
            CAL_SETTLE: begin
               if (cnt_q == 8'(CAL_SETTLE_CYC - 1)) begin
                  state_q <= CAL_PROBE;
                  cnt_q   <= 8'h00;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            CAL_PROBE: begin
               state_q <= CAL_WAIT;
               cnt_q   <= 8'h00;
            end
            CAL_WAIT: begin
               if (in_valid || cnt_q == 8'(CAL_TIMEOUT_CYC)) begin
                  state_q <= CAL_DONE;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            CAL_DONE: begin
               state_q <= CAL_DONE;
            end
         endcase
      end
   end

   // status flags; both are final until reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         success_q <= 1'b0;
         fail_q    <= 1'b0;
      end else if (state_q == CAL_WAIT) begin
         if (in_valid) begin
            success_q <= 1'b1;
         end else if (cnt_q == 8'(CAL_TIMEOUT_CYC)) begin
            fail_q <= 1'b1;
         end
      end
   end

   // capture window after each read, held open through CAL_WAIT; a late strobe after a controller read is discarded
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_q <= 4'h0;
      end else if (read_start) begin
         win_q <= 4'(RD_WINDOW_CYC);
      end else if (state_q == CAL_WAIT) begin
         win_q <= 4'h1;
      end else if (win_q != 4'h0 && !in_valid) begin
         win_q <= win_q - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_cnt_q   <= '0;
         lat_armed_q <= 1'b0;
         rlat_q      <= '0;
      end else if (read_start) begin
         lat_cnt_q   <= LATENCY_FIELD_WIDTH'(1);
         lat_armed_q <= 1'b1;
      end else if (lat_armed_q) begin
         if (in_valid) begin
            rlat_q      <= lat_cnt_q;
            lat_armed_q <= 1'b0;
         end else if (lat_cnt_q != '1) begin
            lat_cnt_q <= lat_cnt_q + LATENCY_FIELD_WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wlat_q <= '0;
      end else if (state_q == CAL_WAIT && in_valid) begin
         wlat_q <= WRITE_LAT_WIDTH'(lat_cnt_q);
      end
   end

   // two-entry read buffer: head drives the bus, spare absorbs a stall
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_q     <= '0;
         head_ph_q  <= '0;
         spare_q    <= '0;
         spare_ph_q <= '0;
         spare_v_q  <= 1'b0;
      end else if (pop || !(|head_ph_q)) begin
         if (spare_v_q) begin
            head_q     <= spare_q;
            head_ph_q  <= spare_ph_q;
            spare_q    <= rdata_s2_q;
            spare_ph_q <= dqs_s2_q;
            spare_v_q  <= in_valid;
         end else begin
            head_q     <= rdata_s2_q;
            head_ph_q  <= push ? dqs_s2_q : '0;
         end
      end else if (push) begin
         spare_q    <= rdata_s2_q;
         spare_ph_q <= dqs_s2_q;
         spare_v_q  <= 1'b1;
      end
   end

   assign ctl.rdata       = head_q;
   assign ctl.rdata_valid = head_ph_q;
   assign ctl.rlat        = rlat_q;
   assign ctl.wlat        = wlat_q;
   assign ctl.cal_success = success_q;
   assign ctl.cal_fail    = fail_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_accept_o <= 1'b0;
      end else begin
         rd_accept_o <= !(spare_v_q || push);
      end
   end

   // command pins; probe read during calibration, controller only after success
   // lane select left unused
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_addr_o  <= '0;
         mem_ba_o    <= '0;
         mem_cke_o   <= '0;
         mem_cs_n_o  <= '1;
         mem_odt_o   <= '0;
         mem_ras_n_o <= '1;
         mem_cas_n_o <= '1;
         mem_we_n_o  <= '1;
         mem_rst_n_o <= '0;
      end else if (!success_q) begin
         mem_addr_o  <= '0;
         mem_ba_o    <= '0;
         mem_cke_o   <= '1;
         mem_cs_n_o  <= probe ? '0 : '1;
         mem_odt_o   <= '0;
         mem_ras_n_o <= '1;
         mem_cas_n_o <= probe ? '0 : '1;
         mem_we_n_o  <= '1;
         mem_rst_n_o <= '1;
      end else begin
         mem_addr_o  <= ctl.addr;
         mem_ba_o    <= ctl.ba;
         mem_cke_o   <= ctl.cke;
         mem_cs_n_o  <= ctl.cs_n;
         mem_odt_o   <= ctl.odt;
         mem_ras_n_o <= ctl.ras_n;
         mem_cas_n_o <= ctl.cas_n;
         mem_we_n_o  <= ctl.we_n;
         mem_rst_n_o <= ctl.rst_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_clk_en_o <= '0;
      end else begin
         mem_clk_en_o <= ~ctl.mem_clk_disable;
      end
   end

endmodule // phy_cmd_read_cal

//--- hw/mem_ctl_end.sv
`timescale 1ns/10ps
module mem_ctl_end
   import phy_port_pkg::*;
(
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // phy side
   phy_port_if.ctl                            phy,
   // command requests
   input  wire logic                          req_valid_i,
   output logic                               req_ready_o,
   input  wire logic [2:0]                    req_cmd_i,
   input  wire logic                          req_phase_i,
   input  wire logic [ROW_ADDRESS_WIDTH-1:0]  req_row_i,
   input  wire logic [BANK_ADDRESS_WIDTH-1:0] req_bank_i,
   input  wire logic                          clk_off_i,
   // read return
   output logic [RDATA_WIDTH-1:0]             rd_data_o,
   output logic [PHASES-1:0]                  rd_valid_o,
   input  wire logic                          rd_ready_i,
   // status
   output logic                               cal_ok_o,
   output logic                               cal_fail_o
);

   logic [ROW_ADDRESS_WIDTH*PHASES-1:0]  addr_q;
   logic [BANK_ADDRESS_WIDTH*PHASES-1:0] ba_q;
   logic [PHASES-1:0] ras_n_q;
   logic [PHASES-1:0] cas_n_q;
   logic [PHASES-1:0] we_n_q;
   logic [PHASES-1:0] cs_n_q;
   logic [PHASES-1:0] drd_q;
   logic              rst_n_q;
   logic              clk_dis_q;
   logic              take;

   assign take = req_valid_i && req_ready_o;

   // traffic only between success and fail
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_ready_o <= 1'b0;
         cal_ok_o    <= 1'b0;
         cal_fail_o  <= 1'b0;
      end else begin
         req_ready_o <= phy.cal_success && !phy.cal_fail;
         cal_ok_o    <= phy.cal_success;
         cal_fail_o  <= phy.cal_fail;
      end
   end

   // one command slot per phase, the other a nop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_q  <= '0;
         ba_q    <= '0;
         ras_n_q <= '1;
         cas_n_q <= '1;
         we_n_q  <= '1;
         cs_n_q  <= '1;
         drd_q   <= '0;
      end else begin
         addr_q  <= {PHASES{req_row_i}};
         ba_q    <= {PHASES{req_bank_i}};
         ras_n_q <= '1;
         cas_n_q <= '1;
         we_n_q  <= '1;
         cs_n_q  <= '1;
         drd_q   <= '0;
         if (take && req_cmd_i != CMD_NOP) begin
            ras_n_q[req_phase_i] <= req_cmd_i[2];
            cas_n_q[req_phase_i] <= req_cmd_i[1];
            we_n_q[req_phase_i]  <= req_cmd_i[0];
            cs_n_q[req_phase_i]  <= 1'b0;
            drd_q[req_phase_i]   <= (req_cmd_i == CMD_READ);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_n_q   <= 1'b0;
         clk_dis_q <= 1'b0;
      end else begin
         rst_n_q   <= 1'b1;
         clk_dis_q <= clk_off_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o  <= '0;
         rd_valid_o <= '0;
      end else if (!(|rd_valid_o) || rd_ready_i) begin
         rd_data_o  <= phy.rdata;
         rd_valid_o <= phy.rdata_valid;
      end
   end

   assign phy.rdata_ready = !(|rd_valid_o) || rd_ready_i;
   assign phy.addr        = addr_q;
   assign phy.ba          = ba_q;
   assign phy.ras_n       = ras_n_q;
   assign phy.cas_n       = cas_n_q;
   assign phy.we_n        = we_n_q;
   assign phy.cs_n        = CS_PH_WIDTH'({CHIP_SELECT_COUNT{cs_n_q}});
   assign phy.cke         = {CS_PH_WIDTH{rst_n_q}};
   assign phy.odt         = '0;
   assign phy.doing_rd    = DRD_WIDTH'({STROBE_GROUP_COUNT{drd_q}});
   assign phy.rst_n       = {PHASES{rst_n_q}};
   assign phy.mem_clk_disable = {CLOCK_PAIR_COUNT{clk_dis_q}};
   assign phy.cal_req     = 1'b0;
   assign phy.cal_byte_lane_sel_n = '1;

endmodule // mem_ctl_end

//--- bench/phy_port_assertions.sv
`timescale 1ns/10ps
module phy_port_checker
   import phy_port_pkg::*;
(
   // clock and reset
   input wire logic                                 clk_i,
   input wire logic                                 rst_i,
   // read return
   input wire logic [RDATA_WIDTH-1:0]               rdata,
   input wire logic [PHASES-1:0]                    rdata_valid,
   input wire logic                                 rdata_ready,
   input wire logic [WRITE_LAT_WIDTH-1:0]           wlat,
   // commands
   input wire logic [DRD_WIDTH-1:0]                 doing_rd,
   input wire logic [ROW_ADDRESS_WIDTH*PHASES-1:0]  addr,
   input wire logic [BANK_ADDRESS_WIDTH*PHASES-1:0] ba,
   input wire logic [CS_PH_WIDTH-1:0]               cke,
   input wire logic [CS_PH_WIDTH-1:0]               cs_n,
   input wire logic [CS_PH_WIDTH-1:0]               odt,
   input wire logic [PHASES-1:0]                    ras_n,
   input wire logic [PHASES-1:0]                    cas_n,
   input wire logic [PHASES-1:0]                    we_n,
   input wire logic [PHASES-1:0]                    rst_n,
   // calibration
   input wire logic                                 cal_success,
   input wire logic                                 cal_fail,
   input wire logic                                 cal_req,
   input wire logic [LANE_WIDTH-1:0]                cal_byte_lane_sel_n
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   success_sticky_a: assert property (
      cal_success |=> cal_success) else $error("success flag dropped");
   fail_sticky_a: assert property (
      cal_fail |=> cal_fail && !cal_success) else $error("fail flag dropped");
   wlat_frozen_a: assert property (
      cal_success && $past(cal_success) |-> $stable(wlat))
      else $error("write latency moved");
   idle_before_cal_a: assert property (
      !cal_success || cal_fail |-> cs_n == '1)
      else $error("command outside calibrated state");
   read_flag_a: assert property (
      doing_rd == (~cas_n & ras_n & we_n)) else $error("read flag mismatch");
   one_slot_a: assert property (
      cs_n != '0) else $error("both slots selected");
   addr_pairs_a: assert property (
      cs_n != '1 |-> addr[ROW_ADDRESS_WIDTH-1:0] ==
      addr[2*ROW_ADDRESS_WIDTH-1:ROW_ADDRESS_WIDTH] &&
      ba[BANK_ADDRESS_WIDTH-1:0] ==
      ba[2*BANK_ADDRESS_WIDTH-1:BANK_ADDRESS_WIDTH])
      else $error("slot address differs");
   pins_awake_a: assert property (
      !$past(rst_i) |-> cke == '1 && odt == '0 && rst_n == '1)
      else $error("cke odt or reset wrong");
   valid_stands_a: assert property (
      rdata_valid != '0 && !rdata_ready |=>
      $stable(rdata_valid) && $stable(rdata))
      else $error("read word not held");
   unsupported_idle_a: assert property (
      !cal_req && cal_byte_lane_sel_n == '1)
      else $error("unsupported inputs driven");
endmodule // phy_port_checker

//--- bench/tb_ddr_phy_cmd_read_cal_port.sv
`timescale 1ns/10ps
module tb_ddr_phy_cmd_read_cal_port;
   import phy_port_pkg::*;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic        req_valid_i = 1'b0;
   logic [2:0]  req_cmd_i   = CMD_NOP;
   logic        req_phase_i = 1'b0;
   logic [12:0] req_row_i   = 13'h0000;
   logic [2:0]  req_bank_i  = 3'h0;
   logic        clk_off_i   = 1'b0;
   logic        rd_ready_i  = 1'b1;
   logic [31:0] mem_rdata_i = 32'h0000_0000;
   logic [1:0]  mem_dqs_i   = 2'b00;
   logic [25:0] mem_addr_o;
   logic [5:0]  mem_ba_o;
   logic [1:0]  mem_cke_o, mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_odt_o;
   logic [1:0]  mem_we_n_o, mem_rst_n_o, rd_valid_o;
   logic        mem_clk_en_o, rd_accept_o, req_ready_o, cal_ok_o, cal_fail_o;
   logic [31:0] rd_data_o;
   logic [4:0]  wlat_seen;
   int          n_mismatch   = 0;
   int          total_checks = 0;

   always #10 clk_i = ~clk_i;

   phy_port_if bus_if ();
   phy_cmd_read_cal u_phy_cmd_read_cal (.clk_i(clk_i), .rst_i(rst_i),
      .ctl(bus_if), .mem_addr_o(mem_addr_o), .mem_ba_o(mem_ba_o),
      .mem_cke_o(mem_cke_o), .mem_cs_n_o(mem_cs_n_o), .mem_odt_o(mem_odt_o),
      .mem_ras_n_o(mem_ras_n_o), .mem_cas_n_o(mem_cas_n_o),
      .mem_we_n_o(mem_we_n_o), .mem_rst_n_o(mem_rst_n_o),
      .mem_clk_en_o(mem_clk_en_o), .mem_rdata_i(mem_rdata_i),
      .mem_dqs_i(mem_dqs_i), .rd_accept_o(rd_accept_o));
   mem_ctl_end u_mem_ctl_end (.clk_i(clk_i), .rst_i(rst_i), .phy(bus_if),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_cmd_i(req_cmd_i), .req_phase_i(req_phase_i),
      .req_row_i(req_row_i), .req_bank_i(req_bank_i), .clk_off_i(clk_off_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .rd_ready_i(rd_ready_i), .cal_ok_o(cal_ok_o), .cal_fail_o(cal_fail_o));
   phy_port_checker u_phy_port_checker (.clk_i(clk_i), .rst_i(rst_i),
      .rdata(bus_if.rdata), .rdata_valid(bus_if.rdata_valid),
      .rdata_ready(bus_if.rdata_ready), .wlat(bus_if.wlat),
      .doing_rd(bus_if.doing_rd), .addr(bus_if.addr), .ba(bus_if.ba),
      .cke(bus_if.cke), .cs_n(bus_if.cs_n), .odt(bus_if.odt),
      .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
      .rst_n(bus_if.rst_n), .cal_success(bus_if.cal_success),
      .cal_fail(bus_if.cal_fail), .cal_req(bus_if.cal_req),
      .cal_byte_lane_sel_n(bus_if.cal_byte_lane_sel_n));

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // reset, then run calibration; the probe is answered only when asked
   task cal(input bit answer);
      int i;
      rst_i = 1'b1;
      cyc(3);
      chk(mem_cs_n_o, 2'b11, "cs_n in reset");
      chk(mem_rst_n_o, 2'b00, "memory reset in reset");
      chk(mem_cke_o, 2'b00, "cke in reset");
      chk(req_ready_o, 1'b0, "ready in reset");
      rst_i = 1'b0;
      for (i = 0; i < 300 && !cal_ok_o && !cal_fail_o; i++) begin
         @(negedge clk_i);
         mem_dqs_i = {2{answer && mem_cas_n_o == 2'b00}};
      end
      mem_dqs_i = 2'b00;
   endtask

   task t_fail;
      req_valid_i = 1'b1;
      req_cmd_i = CMD_READ;
      cal(1'b0);
      cyc(3);
      chk(cal_fail_o, 1'b1, "no fail flag");
      chk(bus_if.cal_fail, 1'b1, "no phy fail flag");
      chk(cal_ok_o, 1'b0, "success after failure");
      chk(req_ready_o, 1'b0, "ready after failure");
      req_valid_i = 1'b0;
      $display("t_fail done");
   endtask

   task t_good;
      cal(1'b1);
      cyc(3);
      chk(cal_ok_o, 1'b1, "no success flag");
      chk(cal_fail_o, 1'b0, "fail with success");
      chk(req_ready_o, 1'b1, "not ready after success");
      wlat_seen = bus_if.wlat;
      $display("t_good done");
   endtask

   task issue(input logic [2:0] cmd, input logic ph, input logic [12:0] row,
              input logic [2:0] bank);
      req_valid_i = 1'b1;
      req_cmd_i = cmd;
      req_phase_i = ph;
      req_row_i = row;
      req_bank_i = bank;
      @(negedge clk_i);
      req_valid_i = 1'b0;
   endtask

   task t_cmd;
      logic [12:0] row;
      logic [2:0]  bank;
      logic [1:0]  sel_n;
      for (int ph = 0; ph < 2; ph++) begin
         row = ph ? 13'h0f0f : 13'h1a5c;
         bank = ph ? 3'h2 : 3'h5;
         sel_n = ph ? 2'b01 : 2'b10;
         issue(CMD_READ, ph[0], row, bank);
         chk(bus_if.doing_rd, 2'(~sel_n), "read flag");
         cyc(1);
         chk(mem_cas_n_o, sel_n, "cas_n slot");
         chk(mem_cs_n_o, sel_n, "cs_n slot");
         chk({mem_ras_n_o, mem_we_n_o}, 4'hf, "ras_n we_n");
         chk(mem_addr_o, {row, row}, "row fields");
         chk(mem_ba_o, {bank, bank}, "bank fields");
         chk({mem_cke_o, mem_odt_o, mem_rst_n_o}, 6'h33, "cke odt rst");
         cyc(1);
         chk(mem_cs_n_o, 2'b11, "command not one cycle");
      end
      issue(CMD_NOP, 1'b0, 13'h0001, 3'h1);
      cyc(2);
      chk(mem_cs_n_o, 2'b11, "nop issued");
      $display("t_cmd done");
   endtask

   task t_read;
      logic [15:0] w;
      int          i;
      for (int k = 0; k < 2; k++) begin
         w = k ? 16'h5a3c : 16'hc3a5;
         issue(CMD_READ, k[0], 13'h0000, 3'h0);
         cyc(2 + k);
         mem_rdata_i = {w, w};
         mem_dqs_i = k ? 2'b10 : 2'b01;
         cyc(1);
         mem_dqs_i = 2'b00;
         mem_rdata_i = ~mem_rdata_i;
         for (i = 0; i < 20 && rd_valid_o == 2'b00; i++) cyc(1);
         chk(rd_valid_o, k ? 2'b10 : 2'b01, "valid phase");
         chk(rd_data_o[16*k+:16], w, "read word");
         chk(bus_if.rlat, 4 + k, "read latency");
         cyc(10);
      end
      $display("t_read done");
   endtask

   // stall the receiver while four words arrive; three fit, in order
   task t_stall;
      int n;
      rd_ready_i = 1'b0;
      issue(CMD_READ, 1'b0, 13'h0000, 3'h0);
      cyc(1);
      for (int i = 0; i < 4; i++) begin
         mem_rdata_i = {2{16'h1100 + 16'(i)}};
         mem_dqs_i = i[0] ? 2'b10 : 2'b01;
         cyc(1);
      end
      mem_dqs_i = 2'b00;
      mem_rdata_i = ~mem_rdata_i;
      cyc(8);
      chk(rd_accept_o, 1'b0, "buffer not full");
      rd_ready_i = 1'b1;
      n = 0;
      // the first held word is already on the output; look before stepping
      repeat (12) begin
         if (rd_valid_o != 2'b00) begin
            chk(rd_valid_o, n[0] ? 2'b10 : 2'b01, "drain phase");
            chk(rd_data_o[16*n[0]+:16], 16'h1100 + 16'(n), "order");
            n++;
         end
         cyc(1);
      end
      chk(n, 3, "word count after stall");
      chk(rd_accept_o, 1'b1, "no room after drain");
      $display("t_stall done");
   endtask

   task t_clk_off;
      for (int v = 1; v >= 0; v--) begin
         clk_off_i = v[0];
         for (int i = 0; i < 8 && mem_clk_en_o !== !v[0]; i++) cyc(1);
         chk(mem_clk_en_o, !v[0], "clock pair enable");
      end
      chk(bus_if.wlat, wlat_seen, "write latency moved");
      $display("t_clk_off done");
   endtask

   initial begin
      #200_000;
      n_mismatch++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end

   initial begin
      t_fail();
      t_good();
      t_cmd();
      t_read();
      t_stall();
      t_clk_off();
      results();
   end
endmodule // tb_ddr_phy_cmd_read_cal_port
